// ### tb/tb.sv
// tb: self-checking bench of the time code host register port.
// assumes tcp_pkg and tcp_regs.svh are compiled ahead of it.
`timescale 1ns/1ps

module tb;
  import tcp_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] addr;
  logic rd_n, wr_n, tc_sel_n, ser_sel_n;
  logic [7:0] hdata, dout, ind_rdata, wr_data;
  logic oe, irq, uart_rd, ind_wr, ind_rd, uart_wr, uart_addr, uw_addr;
  logic [5:0] ind_ptr, ind_acc, w_addr, rx_idx, r_idx;
  logic [7:0] w_data, uw_data;
  logic fstart, tx_act;
  logic [9:0] vline, v0;
  int n_ird = 0, n_uwr = 0, n_fs = 0;
  logic rx_we, tx_copy, rxf = 1'b0, txe = 1'b0, tx_on = 1'b0, tx_bit = 1'b0;
  logic [7:0] uart_rdata = 8'h3C, line_cfg = 8'h20;
  logic [1:0] vitc_err = 2'h2, sync_sel = 2'h1;
  logic cf_pin = 1'b1, click = 1'b0;
  tcp_ltc_rx_t ltc_rx = '0;
  tcp_vid_t vid = {1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 10'h001};
  int err_count = 0, num_checks = 0, n_we = 0, n_cp = 0, n_urd = 0, n0;

  always #5 mclk_in = ~mclk_in;
  // indirect register file stand-in: value depends on the pointer
  assign ind_rdata = {2'h0, ind_ptr} ^ 8'hA5;

  tcp_host_model u_tcp_host_model (.clk_in(mclk_in), .data_in(dout),
    .data_oe_in(oe), .addr_out(addr), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .tc_sel_n_out(tc_sel_n), .ser_sel_n_out(ser_sel_n),
    .data_out(hdata));

  tcp_port #(.FREE_LINE_CYC(8)) u_tcp_port (.mclk_in(mclk_in),
    .rst_in(rst_in), .addr_in(addr), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .timecode_port_select_n_in(tc_sel_n),
    .serial_port_select_n_in(ser_sel_n), .data_in(hdata),
    .data_out(dout), .data_oe_out(oe), .irq_out(irq),
    .uart_rdata_in(uart_rdata), .uart_rx_full_irq_in(rxf),
    .uart_tx_empty_irq_in(txe), .uart_rd_out(uart_rd),
    .uart_wr_out(uart_wr), .uart_addr_out(uart_addr),
    .ind_rdata_in(ind_rdata), .ind_ptr_out(ind_ptr),
    .ind_acc_addr_out(ind_acc), .ind_rd_out(ind_rd), .ind_wr_out(ind_wr),
    .wr_data_out(wr_data), .longitudinal_tx_on_in(tx_on),
    .ltc_sync_sel_in(sync_sel), .line_int_cfg_in(line_cfg),
    .vitc_err_in(vitc_err), .ltc_rx_in(ltc_rx), .rx_buf_we_out(rx_we),
    .rx_buf_idx_out(rx_idx), .ltc_tx_bit_in(tx_bit),
    .ltc_frame_start_out(fstart), .ltc_tx_active_out(tx_act),
    .ltc_tx_copy_out(tx_copy), .vid_in(vid),
    .colour_frame_pin_in(cf_pin), .click_pin_in(click),
    .video_line_out(vline));

  // pulse outputs last one cycle, so count them here
  always @(posedge mclk_in)
  begin
    n_we <= n_we + int'(rx_we);
    n_cp <= n_cp + int'(tx_copy);
    n_urd <= n_urd + int'(uart_rd);
    n_ird <= n_ird + int'(ind_rd);
    n_uwr <= n_uwr + int'(uart_wr);
    n_fs <= n_fs + int'(fstart);
    if (rx_we)
      r_idx <= rx_idx;
    if (uart_wr)
    begin
      uw_addr <= uart_addr;
      uw_data <= wr_data;
    end
    if (ind_wr)
    begin
      w_addr <= ind_acc;
      w_data <= wr_data;
    end
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic o;
    u_tcp_host_model.acc(1'b1, 1'b0, 1'b0, a, d, q, o);
  endtask

  task rd(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic o;
    u_tcp_host_model.acc(1'b0, 1'b0, 1'b0, a, 8'h00, q, o);
    check(q, e);
    check({7'h00, o}, 8'h01);
  endtask

  task idle(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  task rxp(input tcp_ltc_rx_t v, input int n);
    repeat (n)
    begin
      @(negedge mclk_in);
      ltc_rx <= v;
      @(negedge mclk_in);
      ltc_rx <= '0;
    end
  endtask

  task txp(input int n);
    repeat (n)
    begin
      @(negedge mclk_in);
      tx_bit <= 1'b1;
      @(negedge mclk_in);
      tx_bit <= 1'b0;
    end
  endtask

  function automatic logic [7:0] ind(input logic [5:0] p);
    return {2'h0, p} ^ 8'hA5;
  endfunction

  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_count++;
    report_and_stop;
  end

  initial
  begin
    logic [7:0] q;
    logic o;
    repeat (6) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_in <= 1'b0;
    check({7'h00, irq}, 8'h00);
    rd(2'h0, 8'h80);
    rd(2'h2, 8'h00);
    rd(2'h1, 8'h11);
    wr(2'h1, 8'hFF);
    rd(2'h1, 8'h11);
    rxp(5'b01000, 1);
    rd(2'h1, 8'h1D);
    rxp(5'b10000, 1);
    rd(2'h1, 8'h15);
    rxp(5'b00010, 1);
    rd(2'h1, 8'h11);
    vid.field <= 1'b1;
    vid.line <= 10'h003;
    rd(2'h1, 8'h11);
    vid.line <= 10'h006;
    rd(2'h1, 8'h51);
    vid.pal <= 1'b1;
    vid.cframe <= 1'b1;
    vid.line <= 10'h007;
    rd(2'h1, 8'hD1);
    wr(2'h2, 8'h85);
    rd(2'h2, 8'h85);
    check({2'h0, ind_ptr}, 8'h05);
    rd(2'h3, ind(6'h05));
    rd(2'h3, ind(6'h06));
    check({2'h0, ind_ptr}, 8'h07);
    check(8'(n_ird), 8'h02);
    check({7'h00, oe}, 8'h00);
    wr(2'h2, 8'hBF);
    rd(2'h3, ind(6'h3F));
    check({2'h0, ind_ptr}, 8'h00);
    wr(2'h2, 8'h12);
    wr(2'h3, 8'h5A);
    rd(2'h3, ind(6'h12));
    check({2'h0, w_addr}, 8'h12);
    check(w_data, 8'h5A);
    check({2'h0, ind_ptr}, 8'h12);
    // strobe with no select must not reach either group
    n0 = n_urd;
    u_tcp_host_model.acc(1'b0, 1'b0, 1'b1, 2'h3, 8'h00, q, o);
    check({7'h00, o}, 8'h00);
    check(8'(n_urd - n0), 8'h00);
    check({2'h0, ind_ptr}, 8'h12);
    u_tcp_host_model.acc(1'b0, 1'b1, 1'b0, 2'h0, 8'h00, q, o);
    check(q, 8'h3C);
    check(8'(n_urd - n0), 8'h01);
    n0 = n_uwr;
    u_tcp_host_model.acc(1'b1, 1'b1, 1'b0, 2'h1, 8'h77, q, o);
    check(8'(n_uwr - n0), 8'h01);
    check({7'h00, uw_addr}, 8'h01);
    check(uw_data, 8'h77);
    // bits before sync must not land in the receive buffer
    n0 = n_we;
    rxp(5'b00100, 3);
    rxp(5'b10000, 1);
    rxp(5'b00100, 64);
    idle(3);
    check(8'(n_we - n0), 8'h40);
    check({2'h0, r_idx}, 8'h3F);
    check({7'h00, irq}, 8'h00);
    wr(2'h0, 8'h01);
    check({7'h00, irq}, 8'h01);
    rd(2'h0, 8'h89);
    check({7'h00, irq}, 8'h00);
    rd(2'h0, 8'h81);
    tx_on <= 1'b1;
    wr(2'h0, 8'h02);
    check({7'h00, tx_act}, 8'h00);
    click <= 1'b1;
    idle(8);
    check({7'h00, tx_act}, 8'h01);
    check(8'(n_fs), 8'h01);
    n0 = n_cp;
    txp(71);
    idle(3);
    check(8'(n_cp - n0), 8'h00);
    txp(1);
    idle(3);
    check(8'(n_cp - n0), 8'h01);
    check({7'h00, irq}, 8'h01);
    rd(2'h0, 8'h92);
    wr(2'h0, 8'h04);
    line_cfg <= 8'h09;
    vid.line <= 10'h009;
    idle(3);
    vid.line <= 10'h00A;
    idle(3);
    check({7'h00, irq}, 8'h00);
    vid.line <= 10'h00B;
    idle(3);
    check({7'h00, irq}, 8'h01);
    rd(2'h0, 8'hA4);
    rxf <= 1'b1;
    idle(2);
    check({7'h00, irq}, 8'h01);
    rxf <= 1'b0;
    txe <= 1'b1;
    idle(2);
    check({7'h00, irq}, 8'h01);
    txe <= 1'b0;
    idle(2);
    check({7'h00, irq}, 8'h00);
    // without video the internal line counter takes over
    vid.present <= 1'b0;
    rd(2'h1, 8'hC7);
    v0 = vline;
    idle(8);
    check(8'(vline - v0), 8'h01);
    report_and_stop;
  end
endmodule

// ### tb/tcp_host_model.sv
// tcp_host_model: host processor on the 8-bit bus of the time code port.
// assumes the bench calls acc from one process, off the rising edge.
`timescale 1ns/1ps

module tcp_host_model (
  // clock
  input wire logic clk_in,
  // read data from the port
  input wire logic [7:0] data_in,
  input wire logic data_oe_in,
  // bus pins
  output logic [1:0] addr_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic tc_sel_n_out,
  output logic ser_sel_n_out,
  output logic [7:0] data_out
);
  initial
  begin
    addr_out = 2'h0;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    tc_sel_n_out = 1'b1;
    ser_sel_n_out = 1'b1;
    data_out = 8'h00;
  end

  // strobe low 5 cycles: the port needs 4 to agree on it
  task acc(input logic wr, input logic ser, input logic nosel,
    input logic [1:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic oe);
    @(negedge clk_in);
    tc_sel_n_out <= ser | nosel;
    ser_sel_n_out <= ~ser | nosel;
    addr_out <= a;
    data_out <= d;
    rd_n_out <= wr;
    wr_n_out <= ~wr;
    repeat (5) @(negedge clk_in);
    // an undriven bus reads back inverted, so a missing enable shows
    q = data_oe_in ? data_in : ~data_in;
    oe = data_oe_in;
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    // select and data outlast the strobe until its rise is agreed
    repeat (4) @(negedge clk_in);
    tc_sel_n_out <= 1'b1;
    ser_sel_n_out <= 1'b1;
    addr_out <= ~a;
    data_out <= ~d;
    repeat (4) @(negedge clk_in);
  endtask
endmodule

// ### verilog/tcp_pkg.sv
// tcp_pkg: types of the time code host register port.
// assumes tcp_regs.svh is on the include path.
package tcp_pkg;

  // receiver lock state, one-hot
  typedef enum logic [2:0] {
    RX_SEARCH = 3'b001,
    RX_FWD = 3'b010,
    RX_BWD = 3'b100
  } tcp_rx_st_t;

  // pins that pass the synchroniser, rd_n in bit 0
  typedef struct packed {
    logic click;
    logic cframe;
    logic serial_sel_n;
    logic tc_sel_n;
    logic wr_n;
    logic rd_n;
  } tcp_pins_t;

  // one-cycle events from the ltc receiver front end
  typedef struct packed {
    logic sync_fwd;
    logic sync_bwd;
    logic bit_ok;
    logic bit_bad;
    logic sync_missed;
  } tcp_ltc_rx_t;

  // video timing levels
  typedef struct packed {
    logic present;
    logic genlock;
    logic pal;
    logic field;
    logic cframe;
    logic [9:0] line;
  } tcp_vid_t;

  // whole state of the port
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] lvl;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [5:0] ptr;
    logic step;
    logic [5:0] acc_addr;
    logic [2:0] en;
    logic [2:0] flags;
    tcp_rx_st_t rx;
    logic [6:0] rx_cnt;
    logic rx_we;
    logic [5:0] rx_idx;
    logic tx_act;
    logic [6:0] tx_cnt;
    logic tx_copy;
    logic fstart;
    logic field;
    logic frame;
    logic [9:0] prev_line;
    logic [9:0] free_line;
    logic [12:0] free_cnt;
    logic ind_wr;
    logic ind_rd;
    logic uart_wr;
    logic uart_rd;
  } tcp_state_t;

endpackage

// ### verilog/tcp_port.sv
// tcp_port: host register port, interrupt gathering and status of a
// time code reader/generator. Assumes the indirect registers, the uart
// and the analog ltc/video front ends sit outside on the same clock.
//
// How it works
// - two register groups, each own low select
// - locations 0..3 pick control, status, pointer, data
// - location 3 reaches indirect register at pointer
// - pointer is six bits, bits 5..0
// - step bit advances pointer after data access
// - request while flag and enable both set, or on a serial port interrupt
// - reading interrupt control/status clears flags
// - bits 6,7 mirror vitc read errors
// - rx flag on 64th forward bit after sync
// - copy tx data at bit 72, then flag
// - tx double buffered, later data in N+2
// - line flag when chosen line passed, gated
// - serial port full/empty interrupts reach request
// - status shows colour-frame and sync pin levels
// - lock sets on sync, clears on miss/bad
// - direction bit forward 0, backward 1 when locked
// - status bit shows genlock achieved
// - bit 6 field, bit 7 pal colour frame
// - field valid after line 5/2, frame 6
// - receiver takes 1/30 to 80x phase-locked bits
// - rx bits buffered only after valid sync
// - ltc frames start on selected sync event
// - video sync source starts at line 5
// - free-running line timing without video input
// - request and master reset active high
// - line flag line is register value plus one
`timescale 1ns/1ps
`include "tcp_regs.svh"

module tcp_port
  import tcp_pkg::*;
#(
  parameter int FREE_LINE_CYC = `TCP_FREE_LINE_NS / `TCP_CLK_NS
)
(
  // clock and master reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // host bus pins
  input wire logic [1:0] addr_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic timecode_port_select_n_in,
  input wire logic serial_port_select_n_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic irq_out,
  // serial port register set
  input wire logic [7:0] uart_rdata_in,
  input wire logic uart_rx_full_irq_in,
  input wire logic uart_tx_empty_irq_in,
  output logic uart_rd_out,
  output logic uart_wr_out,
  output logic uart_addr_out,
  // indirect registers
  input wire logic [7:0] ind_rdata_in,
  output logic [5:0] ind_ptr_out,
  output logic [5:0] ind_acc_addr_out,
  output logic ind_rd_out,
  output logic ind_wr_out,
  output logic [7:0] wr_data_out,
  // configuration held in indirect registers
  input wire logic longitudinal_tx_on_in,
  input wire logic [1:0] ltc_sync_sel_in,
  input wire logic [7:0] line_int_cfg_in,
  input wire logic [1:0] vitc_err_in,
  // ltc receiver
  input tcp_ltc_rx_t ltc_rx_in,
  output logic rx_buf_we_out,
  output logic [5:0] rx_buf_idx_out,
  // ltc transmitter
  input wire logic ltc_tx_bit_in,
  output logic ltc_frame_start_out,
  output logic ltc_tx_active_out,
  output logic ltc_tx_copy_out,
  // video timing and pins
  input tcp_vid_t vid_in,
  input wire logic colour_frame_pin_in,
  input wire logic click_pin_in,
  output logic [9:0] video_line_out
);

  tcp_state_t s;
  tcp_state_t n;
  tcp_pins_t pins;
  logic [5:0] lvl_nx;
  logic rd_fall;
  logic rd_rise;
  logic wr_rise;
  logic tsel;
  logic usel;
  logic rd_end;
  logic wr_end;
  logic [9:0] line_now;
  logic line_chg;
  logic [2:0] set_v;
  logic [2:0] clr_v;
  logic sync_ev;
  logic [7:0] status_v;

  // true when the captured location is the one asked for
  function automatic logic at_loc(input logic [1:0] a, input logic [1:0] l);
    return a == l;
  endfunction

  assign pins = '{click: click_pin_in, cframe: colour_frame_pin_in,
                  serial_sel_n: serial_port_select_n_in,
                  tc_sel_n: timecode_port_select_n_in,
                  wr_n: wr_n_in, rd_n: rd_n_in};

  // a level moves only once stages two and three agree
  assign lvl_nx = (s.s3 & ~(s.s2 ^ s.s3)) | (s.lvl & (s.s2 ^ s.s3));
  assign rd_fall = s.lvl[0] & ~lvl_nx[0];
  assign rd_rise = ~s.lvl[0] & lvl_nx[0];
  assign wr_rise = ~s.lvl[1] & lvl_nx[1];
  assign tsel = ~s.lvl[2];
  assign usel = ~s.lvl[3];
  assign rd_end = rd_rise & tsel;
  assign wr_end = wr_rise & tsel;

  // free-running timing stands in when no video is seen
  assign line_now = vid_in.present ? vid_in.line : s.free_line;
  assign line_chg = line_now != s.prev_line;
  assign status_v = {s.frame, s.field, 1'b0,
                     vid_in.genlock & vid_in.present,
                     s.rx == RX_BWD, s.rx != RX_SEARCH,
                     s.lvl[5], s.lvl[4]};

  // hardware sets of the three pending flags
  assign set_v[0] = ltc_rx_in.bit_ok & (s.rx == RX_FWD)
                    & (s.rx_cnt == `TCP_RX_LAST_BIT);
  assign set_v[1] = s.tx_copy;
  assign set_v[2] = line_chg
                    & (s.prev_line == {2'h0, line_int_cfg_in}
                       + `TCP_FIRST_LINE);
  // only flags the host was shown are cleared; later sets stay pending
  assign clr_v = (rd_end && at_loc(s.addr, `TCP_LOC_ICS))
                 ? s.rdata[`TCP_ICS_FLAG_LSB +: 3] : 3'h0;
  always_comb
  begin
    case (ltc_sync_sel_in)
      `TCP_SYNC_LINE5: sync_ev = line_chg
                                 & (line_now == `TCP_SYNC_LINE);
      `TCP_SYNC_CLICK: sync_ev = ~s.lvl[5] & lvl_nx[5];
      `TCP_SYNC_RXPAT: sync_ev = ltc_rx_in.sync_fwd | ltc_rx_in.sync_bwd;
      default: sync_ev = wr_end && at_loc(s.addr, `TCP_LOC_DATA)
                         && (s.ptr == `TCP_PTR_LAST);
    endcase
  end

  always_comb
  begin
    n = s;
    n.ind_wr = 1'b0;
    n.ind_rd = 1'b0;
    n.uart_wr = 1'b0;
    n.uart_rd = 1'b0;
    n.rx_we = 1'b0;
    n.tx_copy = 1'b0;
    n.s1 = pins;
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.lvl = lvl_nx;

    // write data and location follow the bus while the write strobe is low
    if (!s.lvl[1])
    begin
      n.wdata = data_in;
      n.addr = addr_in;
    end
    if (rd_fall)
    begin
      n.addr = addr_in;
      if (!lvl_nx[3])
        n.rdata = uart_rdata_in;
      else if (addr_in == `TCP_LOC_ICS)
        n.rdata = {vitc_err_in, s.flags, s.en};
      else if (addr_in == `TCP_LOC_STAT)
        n.rdata = status_v;
      else if (addr_in == `TCP_LOC_PTR)
        n.rdata = {s.step, 1'b0, s.ptr};
      else
        n.rdata = ind_rdata_in;
    end

    // side effects fall at the end of the strobe
    if ((rd_end || wr_end) && at_loc(s.addr, `TCP_LOC_DATA))
    begin
      n.ind_rd = rd_end;
      n.ind_wr = wr_end;
      n.acc_addr = s.ptr;
      if (s.step)
        n.ptr = s.ptr + 6'h01;
    end
    if (wr_end)
    begin
      if (at_loc(s.addr, `TCP_LOC_ICS))
        n.en = s.wdata[`TCP_ICS_EN_LSB +: 3];
      else if (at_loc(s.addr, `TCP_LOC_PTR))
      begin
        n.ptr = s.wdata[5:0];
        n.step = s.wdata[`TCP_PTR_STEP];
      end
    end
    n.uart_rd = rd_rise & usel;
    n.uart_wr = wr_rise & usel;

    // a set in the clearing cycle survives
    n.flags = (s.flags & ~clr_v) | set_v;

    // receiver lock tracking; bits come phase-locked from the front end
    case (s.rx)
      RX_SEARCH: n.rx = RX_SEARCH;
      RX_FWD, RX_BWD:
        if (ltc_rx_in.bit_bad || ltc_rx_in.sync_missed)
          n.rx = RX_SEARCH;
      default: n.rx = RX_SEARCH;
    endcase
    if (ltc_rx_in.bit_ok && s.rx != RX_SEARCH)
    begin
      n.rx_we = s.rx_cnt < `TCP_RX_DATA_BITS;
      n.rx_idx = s.rx_cnt[5:0];
      if (s.rx_cnt != `TCP_CNT_MAX)
        n.rx_cnt = s.rx_cnt + 7'h01;
    end
    if (ltc_rx_in.sync_fwd || ltc_rx_in.sync_bwd)
    begin
      n.rx = ltc_rx_in.sync_fwd ? RX_FWD : RX_BWD;
      n.rx_cnt = 7'h00;
    end

    // transmitter: on only from a frame start, so frames go out whole
    n.fstart = sync_ev;
    if (s.fstart)
    begin
      n.tx_act = longitudinal_tx_on_in;
      n.tx_cnt = 7'h00;
    end
    else if (ltc_tx_bit_in && s.tx_act)
    begin
      if (s.tx_cnt != `TCP_CNT_MAX)
        n.tx_cnt = s.tx_cnt + 7'h01;
      // output buffer swap; later host data waits a whole frame
      n.tx_copy = s.tx_cnt == `TCP_TX_COPY_BIT;
    end

    // field and frame are taken only where they are valid
    n.prev_line = line_now;
    if (line_chg)
    begin
      if (vid_in.pal ? line_now > `TCP_PAL_FIELD_LINE
                     : line_now > `TCP_NTSC_FIELD_LINE)
        n.field = vid_in.field;
      if (!vid_in.pal)
        n.frame = 1'b0;
      else if (line_now > `TCP_PAL_FRAME_LINE)
        n.frame = vid_in.cframe;
    end

    // internal line counter, free running
    if (s.free_cnt == 13'(FREE_LINE_CYC - 1))
    begin
      n.free_cnt = 13'h0000;
      if (s.free_line >= (vid_in.pal ? `TCP_PAL_LINES : `TCP_NTSC_LINES))
        n.free_line = `TCP_FIRST_LINE;
      else
        n.free_line = s.free_line + 10'h001;
    end
    else
      n.free_cnt = s.free_cnt + 13'h0001;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      s <= '0;
      s.s1 <= `TCP_PIN_IDLE;
      s.s2 <= `TCP_PIN_IDLE;
      s.s3 <= `TCP_PIN_IDLE;
      s.lvl <= `TCP_PIN_IDLE;
      s.ptr <= `TCP_PTR_RST;
      s.en <= `TCP_EN_RST;
      s.flags <= `TCP_FLAG_RST;
      s.rx <= RX_SEARCH;
      s.free_line <= `TCP_FIRST_LINE;
    end
    else
      s <= n;
  end

  // bus drive only while select and read strobe agree low
  assign data_oe_out = ~s.lvl[0] & (tsel | usel);
  assign data_out = s.rdata;
  assign irq_out = (|(s.flags & s.en)) | uart_rx_full_irq_in
                   | uart_tx_empty_irq_in;
  assign uart_rd_out = s.uart_rd;
  assign uart_wr_out = s.uart_wr;
  assign uart_addr_out = s.addr[0];
  assign ind_ptr_out = s.ptr;
  assign ind_acc_addr_out = s.acc_addr;
  assign ind_rd_out = s.ind_rd;
  assign ind_wr_out = s.ind_wr;
  assign wr_data_out = s.wdata;
  assign rx_buf_we_out = s.rx_we;
  assign rx_buf_idx_out = s.rx_idx;
  assign ltc_frame_start_out = s.fstart;
  assign ltc_tx_active_out = s.tx_act;
  assign ltc_tx_copy_out = s.tx_copy;
  assign video_line_out = line_now;

  property p_rd_clr;
    @(posedge mclk_in) disable iff (rst_in)
    (rd_end && s.addr == `TCP_LOC_ICS && set_v == 3'h0)
      |=> (s.flags & $past(s.rdata[`TCP_ICS_FLAG_LSB +: 3])) == 3'h0;
  endproperty
  a_rd_clr: assert property (p_rd_clr)
    else $error("flags not cleared by status read");
  property p_set_wins;
    @(posedge mclk_in) disable iff (rst_in)
    set_v[0] |=> s.flags[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("rx frame flag lost");
  property p_irq;
    @(posedge mclk_in) disable iff (rst_in)
    ($rose(s.flags[2]) && s.en[2]) |-> irq_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled line flag gave no request");
  property p_step;
    @(posedge mclk_in) disable iff (rst_in)
    (rd_end && s.addr == `TCP_LOC_DATA && s.step)
      |=> s.ptr == $past(s.ptr) + 6'h01;
  endproperty
  a_step: assert property (p_step)
    else $error("pointer did not step");
  // the strobe level needs four edges to pass the synchroniser
  property p_oe;
    @(posedge mclk_in) disable iff (rst_in)
    rd_n_in [*4] |=> !data_oe_out;
  endproperty
  a_oe: assert property (p_oe)
    else $error("data driven without read strobe");
  property p_tx_flag;
    @(posedge mclk_in) disable iff (rst_in)
    s.tx_copy |=> s.flags[1];
  endproperty
  a_tx_flag: assert property (p_tx_flag)
    else $error("tx load flag missing after copy");
  property p_unlock;
    @(posedge mclk_in) disable iff (rst_in)
    (ltc_rx_in.bit_bad && !ltc_rx_in.sync_fwd && !ltc_rx_in.sync_bwd)
      |=> s.rx == RX_SEARCH;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("lock held after bad bit");
  property p_we;
    @(posedge mclk_in) disable iff (rst_in)
    s.rx_we |-> $past(s.rx) != RX_SEARCH;
  endproperty
  a_we: assert property (p_we)
    else $error("rx buffer written without sync");

endmodule

// ### verilog/tcp_regs.svh
// tcp_regs.svh: offsets, field positions, reset values and timing counts
// of the time code host register port; included by tcp_port.
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH

// direct register locations on the two address lines
`define TCP_LOC_ICS 2'h0
`define TCP_LOC_STAT 2'h1
`define TCP_LOC_PTR 2'h2
`define TCP_LOC_DATA 2'h3

// interrupt control/status fields
`define TCP_ICS_EN_LSB 0
`define TCP_ICS_FLAG_LSB 3
`define TCP_ICS_VITC_LSB 6
`define TCP_EN_RST 3'h0
`define TCP_FLAG_RST 3'h0

// receiver/video status fields
`define TCP_ST_CFRAME 0
`define TCP_ST_CLICK 1
`define TCP_ST_LOCK 2
`define TCP_ST_REV 3
`define TCP_ST_GLOCK 4
`define TCP_ST_FIELD 6
`define TCP_ST_FRAME 7

// indirect pointer fields
`define TCP_PTR_STEP 7
`define TCP_PTR_RST 6'h00
`define TCP_PTR_LAST 6'h3F

// ltc frame positions (bit indices counted from zero)
`define TCP_RX_LAST_BIT 7'h3F
`define TCP_RX_DATA_BITS 7'h40
`define TCP_TX_COPY_BIT 7'h47
`define TCP_CNT_MAX 7'h7F

// ltc sync source codes
`define TCP_SYNC_LINE5 2'h0
`define TCP_SYNC_CLICK 2'h1
`define TCP_SYNC_RXPAT 2'h2
`define TCP_SYNC_IND 2'h3

// video line figures
`define TCP_SYNC_LINE 10'h005
`define TCP_NTSC_FIELD_LINE 10'h005
`define TCP_PAL_FIELD_LINE 10'h002
`define TCP_PAL_FRAME_LINE 10'h006
`define TCP_NTSC_LINES 10'h20D
`define TCP_PAL_LINES 10'h271
`define TCP_FIRST_LINE 10'h001

// pin synchroniser idle value: strobes and selects high
`define TCP_PIN_IDLE 6'h0F

// timing
`define TCP_CLK_NS 10
`define TCP_FREE_LINE_NS 64000

`endif
